// ===== src/cssc_clock_ctrl.sv
// Clock source selection, start-up timing and domain gating
//
// How it works
// - The clock select fuses pick external clock (00), slow oscillator (11) or RC (01, 10).
// - Wake-up from power-down or power-save counts its delay on the selected source.
// - Start from reset with start-up 01, 10 or 11 adds a power settling delay counted on the watchdog oscillator.
// - That delay is 512 watchdog cycles for 4 ms and 8192 for 64 ms.
// - Start-up fuses give 6 clocks after power-down or power-save and 14, 14+4 ms, 14+64 ms after reset.
// - Factory fuses are select 10, start-up 10 and divide-by-eight programmed.
// - A programmed divide-by-eight fuse starts the system clock at one eighth.
// - Reset loads the stored calibration byte into the RC trim register.
// - The watchdog and reset time-out always run from the watchdog oscillator.
// - A gated core clock enable exists and its halt stops all core work.
// - An I/O clock enable exists and external interrupts are caught even while it halts.
// - The flash clock enable runs and stops with the core clock enable.
// - The converter clock enable keeps running in ADC noise reduction sleep, where core and I/O halt.
// - Sleep modes gate off the domains that are not in use.
// - The division factor applies equally to every domain except the watchdog domain.
`timescale 1ns/100ps
`default_nettype none

`include "cssc_defines.svh"

module cssc_clock_ctrl
(
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic rst, // Sync reset, active high
  input wire logic [1:0] clock_source_select_fuses, // Source select
  input wire logic [1:0] startup_delay_fuses, // Start-up delay select
  input wire logic initial_divide_by_eight_fuse, // 0 = programmed
  input wire logic [6:0] stored_trim, // Factory calibration byte
  input wire logic rc_osc_tick, // RC oscillator cycle
  input wire logic ext_clk_tick, // External clock cycle
  input wire logic lf_osc_tick, // Low-frequency oscillator cycle
  input wire logic wdt_osc_tick, // Watchdog oscillator cycle
  input wire logic sleep_req, // Core asks to sleep, pulse
  input wire logic wake_event, // Synchronous wake source
  input wire logic ext_int_level, // External interrupt pin
  input wire logic ext_int_ack, // Clears caught interrupt
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic [6:0] rc_oscillator_trim, // Trim to RC oscillator
  output logic rc_freq_9m6, // RC nominal 9.6 MHz chosen
  output logic cpu_clk_en, // Core domain enable
  output logic flash_clk_en, // Flash domain enable
  output logic io_clk_en, // I/O domain enable
  output logic adc_clk_en, // Converter domain enable
  output logic wdt_clk_en, // Watchdog domain enable
  output logic ext_int_pending // Caught external interrupt
);

  import cssc_pkg::*;

  // ------------------------------------------------
  // Fuse capture and source decode
  // ------------------------------------------------
  logic [1:0] sel_r;
  logic [1:0] sel_nxt;
  logic [1:0] sut_r;
  logic [1:0] sut_nxt;
  logic src_tick;
  logic [13:0] wdt_load;

  always_comb
  begin
    sel_nxt = sel_r;
    sut_nxt = sut_r;
    case (sel_r)
      `CSSC_SEL_EXT: src_tick = ext_clk_tick;
      `CSSC_SEL_LF: src_tick = lf_osc_tick;
      default: src_tick = rc_osc_tick;
    endcase
    case (sut_r)
      `CSSC_SUT_SHORT: wdt_load = `CSSC_WDT_NONE_CYC;
      `CSSC_SUT_4MS: wdt_load = `CSSC_WDT_4MS_CYC;
      default: wdt_load = `CSSC_WDT_64MS_CYC;
    endcase
  end

  // Fuses are only sampled in reset; changing them live is not meaningful
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sel_r <= clock_source_select_fuses;
      sut_r <= startup_delay_fuses;
    end
    else
    begin
      sel_r <= sel_nxt;
      sut_r <= sut_nxt;
    end
  end

  // ------------------------------------------------
  // Start-up counters
  // ------------------------------------------------
  cssc_state_t state_r;
  cssc_state_t state_nxt;
  logic start_r;
  logic src_load;
  logic [13:0] src_load_val;
  logic src_done;
  logic wdt_done;
  logic [1:0] slp_r;

  assign src_load = start_r || ((state_r == CSSC_ST_SLEEP) && (state_nxt == CSSC_ST_WAKE));
  assign src_load_val = start_r ? `CSSC_RESET_CK : `CSSC_WAKE_CK;

  cssc_tick_counter u_src_cnt
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(src_load),
    .load_val(src_load_val),
    .tick(src_tick),
    .done(src_done)
  );

  cssc_tick_counter u_wdt_cnt
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(start_r),
    .load_val(wdt_load),
    .tick(wdt_osc_tick),
    .done(wdt_done)
  );

  // ------------------------------------------------
  // Power state machine
  // ------------------------------------------------
  logic pend_r;
  logic pend_nxt;
  logic deep_sleep;

  assign deep_sleep = (slp_r == CSSC_SLP_PWR_DOWN) || (slp_r == CSSC_SLP_PWR_SAVE);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      CSSC_ST_STARTUP:
        if (!start_r && src_done && wdt_done)
          state_nxt = CSSC_ST_RUN;
      CSSC_ST_RUN:
        if (sleep_req)
          state_nxt = CSSC_ST_SLEEP;
      // Async-caught interrupt still wakes with I/O halted
      CSSC_ST_SLEEP:
        if (wake_event || pend_r)
          state_nxt = deep_sleep ? CSSC_ST_WAKE : CSSC_ST_RUN;
      CSSC_ST_WAKE:
        if (!src_load && src_done)
          state_nxt = CSSC_ST_RUN;
      default: state_nxt = CSSC_ST_STARTUP;
    endcase
  end

  // Set wins over acknowledge
  always_comb
  begin
    pend_nxt = pend_r;
    if (ext_int_ack)
      pend_nxt = 1'b0;
    if (ext_int_level)
      pend_nxt = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r <= CSSC_ST_STARTUP;
      start_r <= 1'b1;
      pend_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      start_r <= 1'b0;
      pend_r <= pend_nxt;
    end
  end

  // ------------------------------------------------
  // Prescaler and domain enables
  // ------------------------------------------------
  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic [7:0] pcnt_r;
  logic [7:0] pcnt_nxt;
  logic [7:0] pmask;
  logic sys_tick;
  logic core_on;
  logic io_on;
  logic adc_on;
  logic en_cpu_nxt;
  logic en_io_nxt;
  logic en_adc_nxt;

  assign pmask = 8'((9'h001 << div_r) - 9'h001);
  assign sys_tick = src_tick && ((pcnt_r & pmask) == pmask);

  always_comb
  begin
    pcnt_nxt = pcnt_r;
    if (src_tick)
      pcnt_nxt = sys_tick ? 8'h00 : (pcnt_r + 8'h01);
    core_on = (state_r == CSSC_ST_RUN);
    io_on = core_on || ((state_r == CSSC_ST_SLEEP) && (slp_r == CSSC_SLP_IDLE));
    adc_on = io_on || ((state_r == CSSC_ST_SLEEP) && (slp_r == CSSC_SLP_ADC_NR));
    en_cpu_nxt = sys_tick && core_on;
    en_io_nxt = sys_tick && io_on;
    en_adc_nxt = sys_tick && adc_on;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pcnt_r <= 8'h00;
      cpu_clk_en <= 1'b0;
      flash_clk_en <= 1'b0;
      io_clk_en <= 1'b0;
      adc_clk_en <= 1'b0;
      wdt_clk_en <= 1'b0;
    end
    else
    begin
      pcnt_r <= pcnt_nxt;
      cpu_clk_en <= en_cpu_nxt;
      flash_clk_en <= en_cpu_nxt;
      io_clk_en <= en_io_nxt;
      adc_clk_en <= en_adc_nxt;
      wdt_clk_en <= wdt_osc_tick;
    end
  end

  // ------------------------------------------------
  // Register slave
  // ------------------------------------------------
  logic [6:0] trim_r;
  logic [6:0] trim_nxt;
  logic [1:0] slp_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_go;
  logic [31:0] status;

  // One wait cycle: request is taken on the edge where ack_r is high
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_go = avs_write && ack_r && avs_byteenable[0];

  always_comb
  begin
    status = `CSSC_ZERO32;
    status[`CSSC_ST_STATE_MSB:`CSSC_ST_STATE_LSB] = state_r;
    status[`CSSC_ST_SEL_MSB:`CSSC_ST_SEL_LSB] = sel_r;
    status[`CSSC_ST_SUT_MSB:`CSSC_ST_SUT_LSB] = sut_r;
    status[`CSSC_ST_PEND] = pend_r;
    status[`CSSC_ST_RC9M6] = (sel_r == `CSSC_SEL_RC_9M6);
  end

  always_comb
  begin
    ack_nxt = (avs_read || avs_write) && !ack_r;
    div_nxt = div_r;
    slp_nxt = slp_r;
    trim_nxt = trim_r;
    rdata_nxt = `CSSC_ZERO32;
    if (wr_go && (avs_address == `CSSC_REG_CTRL))
    begin
      // Out-of-range factors clamp to the largest
      div_nxt = (avs_writedata[`CSSC_CTRL_DIV_MSB:`CSSC_CTRL_DIV_LSB] > `CSSC_DIV_EXP_MAX) ?
        `CSSC_DIV_EXP_MAX : avs_writedata[`CSSC_CTRL_DIV_MSB:`CSSC_CTRL_DIV_LSB];
      slp_nxt = avs_writedata[`CSSC_CTRL_SLP_MSB:`CSSC_CTRL_SLP_LSB];
    end
    if (wr_go && (avs_address == `CSSC_REG_TRIM))
      trim_nxt = avs_writedata[`CSSC_TRIM_W-1:0];
    if (avs_read && !ack_r)
    begin
      case (avs_address)
        `CSSC_REG_CTRL:
        begin
          rdata_nxt[`CSSC_CTRL_DIV_MSB:`CSSC_CTRL_DIV_LSB] = div_r;
          rdata_nxt[`CSSC_CTRL_SLP_MSB:`CSSC_CTRL_SLP_LSB] = slp_r;
        end
        `CSSC_REG_TRIM: rdata_nxt[`CSSC_TRIM_W-1:0] = trim_r;
        `CSSC_REG_STATUS: rdata_nxt = status;
        default: rdata_nxt = `CSSC_ZERO32;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      rdata_r <= `CSSC_ZERO32;
      trim_r <= stored_trim;
      slp_r <= CSSC_SLP_IDLE;
      div_r <= (initial_divide_by_eight_fuse == `CSSC_FUSE_PROGRAMMED) ?
        `CSSC_DIV_EXP_EIGHT : `CSSC_DIV_EXP_ONE;
    end
    else
    begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      trim_r <= trim_nxt;
      slp_r <= slp_nxt;
      div_r <= div_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign rc_oscillator_trim = trim_r;
  assign rc_freq_9m6 = status[`CSSC_ST_RC9M6];
  assign ext_int_pending = pend_r;

endmodule : cssc_clock_ctrl

`default_nettype wire

// ===== inc/cssc_defines.svh
// Constants of the clock source and start-up controller
`ifndef CSSC_DEFINES_SVH
`define CSSC_DEFINES_SVH

// Clock select fuse codes
`define CSSC_SEL_EXT 2'h0
`define CSSC_SEL_RC_4M8 2'h1
`define CSSC_SEL_RC_9M6 2'h2
`define CSSC_SEL_LF 2'h3

// Start-up fuse codes
`define CSSC_SUT_SHORT 2'h0
`define CSSC_SUT_4MS 2'h1
`define CSSC_SUT_64MS 2'h2
`define CSSC_SUT_RSVD 2'h3

// Factory fuse defaults (divide fuse: 0 = programmed)
`define CSSC_SEL_DEFAULT 2'h2
`define CSSC_SUT_DEFAULT 2'h2
`define CSSC_FUSE_PROGRAMMED 1'h0

// Start-up counts in source clocks
`define CSSC_WAKE_CK 14'h0006
`define CSSC_RESET_CK 14'h000E

// Real-time part, printed in ms, counted on the watchdog oscillator
`define CSSC_TOUT_SHORT_MS 4
`define CSSC_TOUT_LONG_MS 64
`define CSSC_WDT_4MS_CYC 14'h0200
`define CSSC_WDT_64MS_CYC 14'h2000
`define CSSC_WDT_NONE_CYC 14'h0000

// Prescaler
`define CSSC_DIV_EXP_ONE 4'h0
`define CSSC_DIV_EXP_EIGHT 4'h3
`define CSSC_DIV_EXP_MAX 4'h8

// Register byte offsets
`define CSSC_REG_CTRL 4'h0
`define CSSC_REG_TRIM 4'h4
`define CSSC_REG_STATUS 4'h8

// CTRL fields
`define CSSC_CTRL_DIV_LSB 0
`define CSSC_CTRL_DIV_MSB 3
`define CSSC_CTRL_SLP_LSB 4
`define CSSC_CTRL_SLP_MSB 5

// STATUS fields
`define CSSC_ST_STATE_LSB 0
`define CSSC_ST_STATE_MSB 3
`define CSSC_ST_SEL_LSB 4
`define CSSC_ST_SEL_MSB 5
`define CSSC_ST_SUT_LSB 6
`define CSSC_ST_SUT_MSB 7
`define CSSC_ST_PEND 8
`define CSSC_ST_RC9M6 9

`define CSSC_TRIM_W 7
`define CSSC_ZERO32 32'h00000000

`endif

// ===== inc/cssc_pkg.sv
// Types of the clock source and start-up controller
package cssc_pkg;

  typedef enum logic [3:0] {
    CSSC_ST_STARTUP = 4'h1,
    CSSC_ST_RUN = 4'h2,
    CSSC_ST_SLEEP = 4'h4,
    CSSC_ST_WAKE = 4'h8
  } cssc_state_t;

  typedef enum logic [1:0] {
    CSSC_SLP_IDLE = 2'h0,
    CSSC_SLP_ADC_NR = 2'h1,
    CSSC_SLP_PWR_DOWN = 2'h2,
    CSSC_SLP_PWR_SAVE = 2'h3
  } cssc_sleep_t;

endpackage : cssc_pkg

// ===== src/cssc_tick_counter.sv
// Down counter of oscillator ticks with a done flag
`timescale 1ns/100ps
`default_nettype none

module cssc_tick_counter
(
  input wire logic clk_sys, // System clock
  input wire logic rst, // Sync reset, active high
  input wire logic load, // Load start value
  input wire logic [13:0] load_val, // Ticks to count
  input wire logic tick, // One oscillator cycle
  output logic done // Count exhausted
);

  logic [13:0] cnt_r;
  logic [13:0] cnt_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (load)
    begin
      cnt_nxt = load_val;
    end
    else if (tick && (cnt_r != 14'h0000))
    begin
      cnt_nxt = cnt_r - 14'h0001;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_r <= 14'h0000;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done = (cnt_r == 14'h0000) && !load;

endmodule : cssc_tick_counter

`default_nettype wire

// ===== verif/cssc_osc_model.sv
// Oscillator model: free-running tick sources for the controller
`timescale 1ns/100ps
`default_nettype none

module cssc_osc_model
#(
  parameter int RC_P = 2, // Periods in system clocks
  parameter int EXT_P = 3,
  parameter int LF_P = 5,
  parameter int WDT_P = 2
)
(
  input wire logic clk_sys, // System clock
  output logic rc_osc_tick, // RC cycle
  output logic ext_clk_tick, // External cycle
  output logic lf_osc_tick, // Slow cycle
  output logic wdt_osc_tick // Watchdog cycle
);
  // ----
  // Tick generators
  // ----
  // Distinct RC, external and slow periods so a wrong source choice shows up in tick counts
  for (genvar g = 0; g < 4; g++)
  begin : g_osc
    localparam int P = (g == 0) ? RC_P : (g == 1) ? EXT_P : (g == 2) ? LF_P : WDT_P;
    int cnt_r = 0;
    logic t_r = 1'h0;
    always_ff @(posedge clk_sys)
    begin
      cnt_r <= (cnt_r == P - 1) ? 0 : cnt_r + 1;
      t_r <= (cnt_r == 0);
    end
  end
  assign rc_osc_tick = g_osc[0].t_r;
  assign ext_clk_tick = g_osc[1].t_r;
  assign lf_osc_tick = g_osc[2].t_r;
  assign wdt_osc_tick = g_osc[3].t_r;
endmodule : cssc_osc_model

`default_nettype wire

// ===== verif/cssc_clock_ctrl_chk.sv
// Assertion checker for the clock source and start-up controller
`timescale 1ns/100ps
`default_nettype none

`include "cssc_defines.svh"

module cssc_clock_ctrl_chk
(
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic [1:0] clock_source_select_fuses, // Source
  input wire logic [1:0] startup_delay_fuses, // Start-up
  input wire logic [6:0] stored_trim, // Calibration
  input wire logic rc_osc_tick, // RC
  input wire logic ext_clk_tick, // External
  input wire logic lf_osc_tick, // Slow
  input wire logic wdt_osc_tick, // Watchdog
  input wire logic ext_int_level, // Pin
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic avs_waitrequest, // Stall
  input wire logic [6:0] rc_oscillator_trim, // Trim
  input wire logic rc_freq_9m6, // Rate
  input wire logic cpu_clk_en, // Core
  input wire logic flash_clk_en, // Flash
  input wire logic io_clk_en, // I/O
  input wire logic adc_clk_en, // Converter
  input wire logic wdt_clk_en, // Watchdog
  input wire logic ext_int_pending // Caught
);
  // ----
  // Tick counts since reset
  // ----
  logic [1:0] sel_r;
  logic [1:0] sut_r;
  logic [13:0] src_r;
  logic [13:0] wdt_r;
  logic src_t;
  logic [13:0] need;
  assign src_t = (sel_r == `CSSC_SEL_EXT) ? ext_clk_tick :
                 (sel_r == `CSSC_SEL_LF) ? lf_osc_tick : rc_osc_tick;
  assign need = (sut_r == `CSSC_SUT_SHORT) ? `CSSC_WDT_NONE_CYC :
                (sut_r == `CSSC_SUT_4MS) ? `CSSC_WDT_4MS_CYC : `CSSC_WDT_64MS_CYC;
  // Saturating, so long runs never wrap back below the limits
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sel_r <= clock_source_select_fuses;
      sut_r <= startup_delay_fuses;
      src_r <= 14'h0000;
      wdt_r <= 14'h0000;
    end
    else
    begin
      if (src_t && src_r != 14'h3FFF) src_r <= src_r + 14'h0001;
      if (wdt_osc_tick && wdt_r != 14'h3FFF) wdt_r <= wdt_r + 14'h0001;
    end
  end

  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence req_rise;
    $rose(avs_read || avs_write);
  endsequence
  sequence one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  bus_one_wait_a: assert property (req_rise |-> one_wait)
    else $error("bus answer not after one wait cycle");
  boot_hold_a: assert property (cpu_clk_en |-> src_r >= `CSSC_RESET_CK && wdt_r >= need)
    else $error("core clock before start-up delay");
  flash_core_pair_a: assert property (flash_clk_en == cpu_clk_en)
    else $error("flash and core enables differ");
  core_needs_io_a: assert property (cpu_clk_en |-> io_clk_en && adc_clk_en)
    else $error("core enable without io and converter");
  adc_outlives_io_a: assert property (io_clk_en |-> adc_clk_en)
    else $error("io enable without converter");
  wdt_follow_a: assert property (wdt_clk_en == ($past(wdt_osc_tick) && !$past(rst)))
    else $error("watchdog enable does not follow oscillator");
  trim_load_a: assert property ($fell(rst) |-> rc_oscillator_trim == $past(stored_trim))
    else $error("trim not loaded in reset");
  rate_select_a: assert property (rc_freq_9m6 == (sel_r == `CSSC_SEL_RC_9M6))
    else $error("rate flag wrong for select");
  int_catch_a: assert property (ext_int_level |=> ext_int_pending)
    else $error("external interrupt not caught");
endmodule : cssc_clock_ctrl_chk

bind cssc_clock_ctrl cssc_clock_ctrl_chk i_cssc_clock_ctrl_chk (.clk_sys, .rst,
  .clock_source_select_fuses, .startup_delay_fuses, .stored_trim, .rc_osc_tick,
  .ext_clk_tick, .lf_osc_tick, .wdt_osc_tick, .ext_int_level, .avs_read, .avs_write,
  .avs_waitrequest, .rc_oscillator_trim, .rc_freq_9m6, .cpu_clk_en, .flash_clk_en,
  .io_clk_en, .adc_clk_en, .wdt_clk_en, .ext_int_pending);

`default_nettype wire

// ===== verif/test_cssc_clock_ctrl.sv
// Testbench of the clock source and start-up controller
`timescale 1ns/100ps
`default_nettype none

`include "cssc_defines.svh"

module test_cssc_clock_ctrl;
  import cssc_pkg::*;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [1:0] clock_source_select_fuses = `CSSC_SEL_DEFAULT;
  logic [1:0] startup_delay_fuses = `CSSC_SUT_DEFAULT;
  logic initial_divide_by_eight_fuse = `CSSC_FUSE_PROGRAMMED;
  logic [6:0] stored_trim = 7'h5A;
  logic sleep_req = 1'h0;
  logic wake_event = 1'h0;
  logic ext_int_level = 1'h0;
  logic ext_int_ack = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [6:0] rc_oscillator_trim;
  logic rc_freq_9m6;
  logic cpu_clk_en;
  logic flash_clk_en;
  logic io_clk_en;
  logic adc_clk_en;
  logic wdt_clk_en;
  logic ext_int_pending;
  logic rc_osc_tick;
  logic ext_clk_tick;
  logic lf_osc_tick;
  logic wdt_osc_tick;
  logic [31:0] q;
  int n_mismatch = 0;
  int cmp_count = 0;
  int t;
  int w;
  int need;
  int ci;
  int ii;
  int ai;
  int cyc;

  always #4 clk_sys = ~clk_sys;

  cssc_osc_model i_cssc_osc_model (.clk_sys, .rc_osc_tick, .ext_clk_tick, .lf_osc_tick,
    .wdt_osc_tick);
  cssc_clock_ctrl i_cssc_clock_ctrl (.clk_sys, .rst, .clock_source_select_fuses,
    .startup_delay_fuses, .initial_divide_by_eight_fuse, .stored_trim, .rc_osc_tick,
    .ext_clk_tick, .lf_osc_tick, .wdt_osc_tick, .sleep_req, .wake_event, .ext_int_level,
    .ext_int_ack, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .rc_oscillator_trim, .rc_freq_9m6, .cpu_clk_en,
    .flash_clk_en, .io_clk_en, .adc_clk_en, .wdt_clk_en, .ext_int_pending);

  // ----
  // Tasks
  // ----
  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request stands until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    if (avs_waitrequest !== 1'b0) n_mismatch++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task run_reset;
    rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
  endtask : run_reset

  function automatic logic src_t();
    case (clock_source_select_fuses)
      `CSSC_SEL_EXT: return ext_clk_tick;
      `CSSC_SEL_LF: return lf_osc_tick;
      default: return rc_osc_tick;
    endcase
  endfunction : src_t

  // Source and watchdog ticks until the next core enable
  task wait_cpu;
    int k;
    t = 0;
    w = 0;
    k = 0;
    @(negedge clk_sys);
    while (cpu_clk_en !== 1'b1 && k < 40000)
    begin
      t += src_t();
      w += wdt_osc_tick;
      k++;
      @(negedge clk_sys);
    end
    cyc = k;
    if (k >= 40000) n_mismatch++;
    @(posedge clk_sys);
  endtask : wait_cpu

  // ----
  // Sequence
  // ----
  initial
  begin
    run_reset;
    wait_cpu;
    chk(32'(w >= 8192 && w < 8256), 32'h1);
    chk(32'(rc_oscillator_trim), 32'h5A);
    bus(1'b0, `CSSC_REG_STATUS, 32'h0);
    chk(q, 32'({1'b1, 1'b0, `CSSC_SUT_DEFAULT, `CSSC_SEL_DEFAULT, CSSC_ST_RUN}));
    bus(1'b0, `CSSC_REG_CTRL, 32'h0);
    chk(q, 32'(`CSSC_DIV_EXP_EIGHT));
    wait_cpu;
    wait_cpu;
    chk(t, 8);
    for (int i = 0; i < 4; i++)
    begin
      clock_source_select_fuses <= i[1:0];
      startup_delay_fuses <= i[1:0];
      initial_divide_by_eight_fuse <= 1'b1;
      run_reset;
      wait_cpu;
      need = (i == 0) ? 0 : (i == 1) ? 512 : 8192;
      chk(32'(w >= need && w < need + 64), 32'h1);
      wait_cpu;
      chk(t, 1);
      chk(cyc, (i == 0) ? 2 : (i == 3) ? 4 : 1);
      chk(32'(rc_freq_9m6), 32'(i == 2));
    end
    clock_source_select_fuses <= `CSSC_SEL_RC_4M8;
    startup_delay_fuses <= `CSSC_SUT_SHORT;
    run_reset;
    wait_cpu;
    bus(1'b1, `CSSC_REG_TRIM, 32'h7F);
    avs_byteenable <= 4'h0;
    bus(1'b1, `CSSC_REG_TRIM, 32'h11);
    avs_byteenable <= 4'hF;
    bus(1'b0, `CSSC_REG_TRIM, 32'h0);
    chk(q, 32'h7F);
    chk(32'(rc_oscillator_trim), 32'h7F);
    bus(1'b1, 4'hC, 32'hFF);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, `CSSC_REG_CTRL, 32'hF);
    bus(1'b0, `CSSC_REG_CTRL, 32'h0);
    chk(q, 32'(`CSSC_DIV_EXP_MAX));
    bus(1'b1, `CSSC_REG_CTRL, 32'h2);
    wait_cpu;
    wait_cpu;
    chk(t, 4);
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, `CSSC_REG_CTRL, 32'(m << 4));
      sleep_req <= 1'b1;
      @(posedge clk_sys);
      sleep_req <= 1'b0;
      repeat (4) @(posedge clk_sys);
      ci = 0;
      ii = 0;
      ai = 0;
      repeat (40)
      begin
        @(negedge clk_sys);
        ci += cpu_clk_en;
        ii += io_clk_en;
        ai += adc_clk_en;
      end
      chk(ci, 0);
      chk(32'(ii > 0), 32'(m == 0));
      chk(32'(ai > 0), 32'(m < 2));
      @(posedge clk_sys);
      // Last mode wakes from the pin, with the I/O domain halted
      if (m == 3) ext_int_level <= 1'b1;
      else wake_event <= 1'b1;
      @(posedge clk_sys);
      ext_int_level <= 1'b0;
      wake_event <= 1'b0;
      wait_cpu;
      chk(32'(t >= 6), 32'(m >= 2));
    end
    chk(32'(ext_int_pending), 32'h1);
    ext_int_ack <= 1'b1;
    @(posedge clk_sys);
    ext_int_ack <= 1'b0;
    @(negedge clk_sys);
    chk(32'(ext_int_pending), 32'h0);
    // Pin and clear in one cycle: the pin wins
    @(posedge clk_sys);
    ext_int_level <= 1'b1;
    ext_int_ack <= 1'b1;
    @(posedge clk_sys);
    ext_int_level <= 1'b0;
    ext_int_ack <= 1'b0;
    @(negedge clk_sys);
    chk(32'(ext_int_pending), 32'h1);
    end_of_test;
  end

  // Longest path is three long reset delays, about 50k cycles
  initial
  begin
    repeat (80000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test;
  end
endmodule : test_cssc_clock_ctrl

`default_nettype wire
